// ===== verilog/ccs_clock_ctrl.sv
// cpu clock source control: registers, oscillator control, stabilisation wait and clock selection
//
// Operation
// - status flag bit 5 ignores software writes
// - status reads 0 main, 1 subsystem
// - reset loads processor clock control 02H
// - main oscillator stopped while reset held
// - speed bit and source bit choose clock
// - fx, fx/4, or subsystem clock /2
// - old clock runs a while after writing
// - switch delay per transition table
// - wait 2^15 fx periods after reset
// - stop and halt allowed on main clock
// - stop refused while subsystem clock selected
// - bit 1 disconnects sub feedback resistor
// - bit 0 stops subsystem oscillator
// - bit 7 stops main oscillator, sub only
// - peripherals on main, watch timer sub
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl
   import ccs_pkg::*;
#(
   parameter int FX_HZ = 5000000,
   parameter int FXT_HZ = 32768,
   parameter int CLK_HZ = 200000000,
   parameter int STAB_CYCLES = 1 << 15
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // oscillator edges, one-cycle pulses synchronous to clk_i
   input wire logic fx_tick_i,
   input wire logic fxt_tick_i,
   // axi4-lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // standby exit, e.g. an interrupt
   input wire logic wake_i,
   // oscillator and clock outputs
   output logic main_osc_en_o,
   output logic sub_osc_en_o,
   output logic feedback_resistor_off_o,
   output logic cpu_run_o,
   output logic cpu_tick_o,
   output logic [1:0] cpu_clk_sel_o,
   output logic periph_tick_o,
   output logic watch_tick_o,
   output logic stop_mode_o,
   output logic halt_mode_o
);
   `include "ccs_cfg.svh"
   initial begin
      if (STAB_CYCLES < 1 || STAB_CYCLES > 65536 || FX_HZ > CLK_HZ) $error("bad clock parameters");
   end
   ////////////////////////////////////////////////////////////////////////////
   // control registers
   logic [7:0] pcc_q;      // processor clock control
   logic [7:0] suboscillator_mode_q;     // suboscillator mode
   logic clock_source_select_q;           // clock source select
   logic status_q;         // cpu clock status, read only
   logic stop_q;           // clock-stopping standby
   logic halt_q;           // cpu-halt standby
   logic refused_q;        // sticky: stop refused on sub clock
   ccs_sel_t cur_sel_q;    // clock in effect
   ccs_state_t st_q;       // controller state
   logic [15:0] stab_q;    // stabilisation count
   logic [1:0] div4_q;     // fx/4 divider
   logic sub_div_q;        // fxt/2 divider
   ccs_switch_if sw();
   // requested setting from bits
   function automatic ccs_sel_t sel_of(input logic clock_source_select, input logic spd);
      if (clock_source_select) return CCS_SEL_SUB;
      return spd ? CCS_SEL_FX4 : CCS_SEL_FX;
   endfunction
   ccs_sel_t req_sel;
   assign req_sel = sel_of(clock_source_select_q, pcc_q[`CCS_BIT_CPU_SPEED_SELECT]);
   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   logic aw_have_q, w_have_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wr_fire;
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign s_axi_bresp = 2'b00;
   // latch address and data in either order, answer after both
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            // byte lane 0 only carries register data
            wdata_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   logic wr_pcc, wr_suboscillator_mode, wr_css, wr_stby;
   assign wr_pcc = wr_fire && awaddr_q == `CCS_OFF_PROC_CLOCK_CTRL;
   assign wr_suboscillator_mode = wr_fire && awaddr_q == `CCS_OFF_SUBOSC_MODE;
   assign wr_css = wr_fire && awaddr_q == `CCS_OFF_SUBCLK_SEL;
   assign wr_stby = wr_fire && awaddr_q == `CCS_OFF_STANDBY;
   ////////////////////////////////////////////////////////////////////////////
   // software registers, reserved bits forced to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pcc_q <= `CCS_RST_PROC_CLOCK_CTRL;
         suboscillator_mode_q <= `CCS_RST_SUBOSC_MODE;
         clock_source_select_q <= 1'b0;
      end else begin
         if (wr_pcc) begin
            pcc_q <= 8'h00;
            pcc_q[`CCS_BIT_CPU_SPEED_SELECT] <= wdata_q[`CCS_BIT_CPU_SPEED_SELECT];
            // main stop only takes while sub clock runs the cpu
            pcc_q[`CCS_BIT_MAIN_OSC_STOP] <= wdata_q[`CCS_BIT_MAIN_OSC_STOP] && status_q;
         end
         if (wr_suboscillator_mode) begin
            suboscillator_mode_q <= {6'h00, wdata_q[1:0]};
         end
         if (wr_css) begin
            clock_source_select_q <= wdata_q[`CCS_BIT_CLOCK_SOURCE_SELECT]; // status bit ignored
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // controller: reset, stabilisation wait, run, switching
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= CCS_ST_RESET;
         stab_q <= '0;
         cur_sel_q <= CCS_SEL_FX4;
         status_q <= 1'b0;
      end else begin
         unique case (st_q)
            CCS_ST_RESET: begin
               st_q <= CCS_ST_STAB;
               stab_q <= 16'(STAB_CYCLES - 1);
            end
            CCS_ST_STAB: begin
               // count 2^15 fx periods before running
               if (fx_tick_i) begin
                  if (stab_q == 16'h0000) st_q <= CCS_ST_RUN;
                  else stab_q <= stab_q - 16'h0001;
               end
            end
            CCS_ST_RUN: begin
               if (req_sel != cur_sel_q) st_q <= CCS_ST_SWITCH;
            end
            CCS_ST_SWITCH: begin
               if (sw.done) begin
                  cur_sel_q <= sw.to_sel;
                  status_q <= (sw.to_sel == CCS_SEL_SUB);
                  st_q <= CCS_ST_RUN;
               end
            end
         endcase
      end
   end
   // start the timer in run when the request differs from the current setting, in switch before done when it differs from the pending one
   logic [1:0] to_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) to_q <= CCS_SEL_FX4;
      else if (sw.start) to_q <= req_sel;
   end
   assign sw.start = (st_q == CCS_ST_RUN && req_sel != cur_sel_q) ||
                     (st_q == CCS_ST_SWITCH && req_sel != ccs_sel_t'(to_q) && !sw.done);
   assign sw.from_sel = cur_sel_q;
   assign sw.to_sel = (st_q == CCS_ST_SWITCH && !sw.start) ? ccs_sel_t'(to_q) : req_sel;
   ////////////////////////////////////////////////////////////////////////////
   // clock dividers: fx/4 and fxt/2
   logic fx4_tick, sub_tick;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div4_q <= 2'b00;
         sub_div_q <= 1'b0;
      end else begin
         if (fx_tick_i) div4_q <= div4_q + 2'b01;
         if (fxt_tick_i) sub_div_q <= !sub_div_q;
      end
   end
   assign fx4_tick = fx_tick_i && div4_q == 2'b11;
   assign sub_tick = fxt_tick_i && sub_div_q;
   ccs_switch_timer #(.FX_HZ(FX_HZ), .FXT_HZ(FXT_HZ), .CNT_W(16)) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .fx_tick_i(fx_tick_i),
      .fx4_tick_i(fx4_tick),
      .sub_tick_i(sub_tick),
      .sw(sw.timer)
   );
   ////////////////////////////////////////////////////////////////////////////
   // standby modes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_q <= 1'b0;
         halt_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         if (wake_i) begin
            stop_q <= 1'b0;
            halt_q <= 1'b0;
         end else if (wr_stby && st_q == CCS_ST_RUN) begin
            if (wdata_q[`CCS_BIT_STOP_REQ] && !status_q) stop_q <= 1'b1;
            if (wdata_q[`CCS_BIT_HALT_REQ]) halt_q <= 1'b1;
         end
         // set wins over clear
         if (wr_stby && wdata_q[`CCS_BIT_STOP_REQ] && status_q) refused_q <= 1'b1;
         else if (wr_stby && wdata_q[`CCS_BIT_STOP_REFUSED]) refused_q <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel, one cycle after address
   logic [7:0] rd_val;
   always_comb begin
      unique case (s_axi_araddr)
         `CCS_OFF_PROC_CLOCK_CTRL: rd_val = pcc_q;
         `CCS_OFF_SUBOSC_MODE: rd_val = suboscillator_mode_q;
         `CCS_OFF_SUBCLK_SEL: rd_val = {2'b00, status_q, clock_source_select_q, 4'h0};
         `CCS_OFF_STANDBY: rd_val = {3'b000, refused_q, halt_q, stop_q, 2'b00};
         default: rd_val = 8'h00;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp = 2'b00;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_val};
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign main_osc_en_o = !rst_i && !pcc_q[`CCS_BIT_MAIN_OSC_STOP] && !stop_q;
   assign sub_osc_en_o = !suboscillator_mode_q[`CCS_BIT_SUB_OSC_STOP];
   assign feedback_resistor_off_o = suboscillator_mode_q[`CCS_BIT_FEEDBACK_RES_OFF];
   assign cpu_run_o = (st_q == CCS_ST_RUN || st_q == CCS_ST_SWITCH) && !stop_q && !halt_q;
   assign cpu_clk_sel_o = cur_sel_q;
   always_comb begin
      unique case (cur_sel_q)
         CCS_SEL_FX: cpu_tick_o = fx_tick_i && cpu_run_o;
         CCS_SEL_FX4: cpu_tick_o = fx4_tick && cpu_run_o;
         default: cpu_tick_o = sub_tick && cpu_run_o;
      endcase
   end
   assign periph_tick_o = fx_tick_i && main_osc_en_o;
   assign watch_tick_o = fxt_tick_i && sub_osc_en_o;
   assign stop_mode_o = stop_q;
   assign halt_mode_o = halt_q;
endmodule
`default_nettype wire

// ===== verilog/ccs_cfg.svh
// register offsets, field positions, reset values and timing constants of the clock source control
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH
`define CCS_OFF_PROC_CLOCK_CTRL 12'hFFB
`define CCS_OFF_SUBOSC_MODE 12'hFF0
`define CCS_OFF_SUBCLK_SEL 12'hFF2
`define CCS_OFF_STANDBY 12'hF00
`define CCS_RST_PROC_CLOCK_CTRL 8'h02
`define CCS_RST_SUBOSC_MODE 8'h00
`define CCS_RST_SUBCLK_SEL 8'h00
`define CCS_BIT_MAIN_OSC_STOP 7
`define CCS_BIT_CPU_SPEED_SELECT 1
`define CCS_BIT_FEEDBACK_RES_OFF 1
`define CCS_BIT_SUB_OSC_STOP 0
`define CCS_BIT_CLOCK_SOURCE_SELECT 4
`define CCS_BIT_CPU_CLOCK_STATUS 5
`define CCS_BIT_STOP_REQ 0
`define CCS_BIT_HALT_REQ 1
`define CCS_BIT_STOP_ACTIVE 2
`define CCS_BIT_HALT_ACTIVE 3
`define CCS_BIT_STOP_REFUSED 4
`define CCS_STAB_EXP 15
`define CCS_FX_DIV_SLOW 4
`define CCS_SUB_DIV 2
`define CCS_INSTR_CYCLES 2
`endif

// ===== verilog/ccs_pkg.sv
// types shared by the clock source control
package ccs_pkg;
   // clock setting as seen by the cpu
   typedef enum logic [1:0] {
      CCS_SEL_FX = 2'b00,
      CCS_SEL_FX4 = 2'b01,
      CCS_SEL_SUB = 2'b11
   } ccs_sel_t;
   // controller states, gray along reset, wait, run, switch
   typedef enum logic [1:0] {
      CCS_ST_RESET = 2'b00,
      CCS_ST_STAB = 2'b01,
      CCS_ST_RUN = 2'b11,
      CCS_ST_SWITCH = 2'b10
   } ccs_state_t;
endpackage

// ===== verilog/ccs_switch_if.sv
// carrier between the controller and its switch timer
`timescale 1ns/1ps
`default_nettype none
interface ccs_switch_if;
   import ccs_pkg::*;
   logic start;
   ccs_sel_t from_sel;
   ccs_sel_t to_sel;
   logic done;
   modport ctrl (output start, output from_sel, output to_sel, input done);
   modport timer (input start, input from_sel, input to_sel, output done);
endinterface
`default_nettype wire

// ===== verilog/ccs_switch_timer.sv
// switch delay timer, counts old-clock cycles before a new cpu clock takes effect
`timescale 1ns/1ps
`default_nettype none
module ccs_switch_timer
   import ccs_pkg::*;
#(
   parameter int FX_HZ = 5000000,
   parameter int FXT_HZ = 32768,
   parameter int CNT_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fx_tick_i,
   input wire logic fx4_tick_i,
   input wire logic sub_tick_i,
   ccs_switch_if.timer sw
);
   `include "ccs_cfg.svh"
   // 2fx/fxT and fx/2fxT in old-clock cycles
   localparam int FX_TO_SUB = (2 * FX_HZ) / FXT_HZ;
   localparam int FX4_TO_SUB = FX_HZ / (2 * FXT_HZ);
   initial begin
      if (FX_TO_SUB >= (1 << CNT_W) || FX_TO_SUB < 1) $error("switch count out of range");
   end
   // delay figure for one transition
   function automatic logic [CNT_W-1:0] delay_of(input ccs_sel_t f, input ccs_sel_t t);
      logic [CNT_W-1:0] r;
      r = CNT_W'(`CCS_INSTR_CYCLES);
      if (f == CCS_SEL_FX && t == CCS_SEL_FX4) r = CNT_W'(2 * `CCS_INSTR_CYCLES);
      else if (f == CCS_SEL_FX && t == CCS_SEL_SUB) r = CNT_W'(FX_TO_SUB);
      else if (f == CCS_SEL_FX4 && t == CCS_SEL_SUB) r = CNT_W'(FX4_TO_SUB);
      return r;
   endfunction
   logic [CNT_W-1:0] cnt_q; // cycles still to run on the old clock
   logic busy_q;            // a switch is pending
   logic done_q;            // one-cycle completion pulse
   logic tick;              // old clock edge
   ccs_sel_t from_q;        // old setting held for the count
   always_comb begin
      unique case (from_q)
         CCS_SEL_FX: tick = fx_tick_i;
         CCS_SEL_FX4: tick = fx4_tick_i;
         default: tick = sub_tick_i;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // count old-clock cycles then pulse done
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         from_q <= CCS_SEL_FX4;
      end else begin
         done_q <= 1'b0;
         if (sw.start) begin
            // restart from the current setting
            cnt_q <= delay_of(sw.from_sel, sw.to_sel);
            from_q <= sw.from_sel;
            busy_q <= 1'b1;
         end else if (busy_q && tick) begin
            if (cnt_q <= CNT_W'(1)) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
            cnt_q <= cnt_q - CNT_W'(1);
         end
      end
   end
   assign sw.done = done_q;
endmodule
`default_nettype wire

// ===== verification/ccs_clock_ctrl_chk.sv
// assertion checker for the cpu clock source control
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fx_tick_i,
   input wire logic fxt_tick_i,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic main_osc_en_o,
   input wire logic sub_osc_en_o,
   input wire logic feedback_resistor_off_o,
   input wire logic cpu_run_o,
   input wire logic [1:0] cpu_clk_sel_o,
   input wire logic periph_tick_o,
   input wire logic watch_tick_o,
   input wire logic stop_mode_o
);
   // both write channels taken at one edge, low byte enabled
   wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////
   // first edge after reset release
   sequence s_rel;
      $fell(rst_i);
   endsequence
   // register write at one address
   sequence s_wr(a);
      wr_go && s_axi_awaddr == a;
   endsequence
   // oscillator held off in reset, checked during reset itself
   property p_osc_held;
      disable iff (1'b0) rst_i |-> !main_osc_en_o;
   endproperty
   a_osc_held: assert property (p_osc_held) else $error("main oscillator runs in reset");
   property p_rst_sel;
      s_rel |-> cpu_clk_sel_o == 2'b01 && !cpu_run_o;
   endproperty
   a_rst_sel: assert property (p_rst_sel) else $error("wrong clock after reset");
   property p_stab_wait;
      s_rel |-> !cpu_run_o [*8];
   endproperty
   a_stab_wait: assert property (p_stab_wait) else $error("cpu ran before stabilisation");
   property p_sub_osc;
      // address and data are latched at the handshake, the register loads one edge later
      s_wr(12'hFF0) |=> ##1 (sub_osc_en_o == !$past(s_axi_wdata[0], 2) &&
                             feedback_resistor_off_o == $past(s_axi_wdata[1], 2));
   endproperty
   a_sub_osc: assert property (p_sub_osc) else $error("sub oscillator controls wrong");
   property p_stop_ref;
      s_wr(12'hF00) ##0 (s_axi_wdata[0] && cpu_clk_sel_o == 2'b11) |=> !stop_mode_o;
   endproperty
   a_stop_ref: assert property (p_stop_ref) else $error("stop entered on sub clock");
   property p_mcc_lock;
      s_wr(12'hFFB) ##0 (s_axi_wdata[7] && cpu_clk_sel_o != 2'b11) |=> main_osc_en_o;
   endproperty
   a_mcc_lock: assert property (p_mcc_lock) else $error("main oscillator stopped on main clock");
   property p_sel_hold;
      (s_wr(12'hFF2) or s_wr(12'hFFB)) |=> $stable(cpu_clk_sel_o) [*2];
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("clock switched at once");
   property p_periph;
      periph_tick_o |-> fx_tick_i && main_osc_en_o;
   endproperty
   a_periph: assert property (p_periph) else $error("peripheral tick not from main clock");
   property p_watch;
      watch_tick_o |-> fxt_tick_i && sub_osc_en_o;
   endproperty
   a_watch: assert property (p_watch) else $error("watch tick not from sub clock");
endmodule
`default_nettype wire

// ===== verification/ccs_clock_ctrl_tb.sv
// self-checking testbench of the cpu clock source control
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl_tb;
   import ccs_pkg::*;
   logic clk_i = 0, rst_i = 1, fx_tick_i = 0, fxt_tick_i = 0, wake_i = 0; // stimulus
   logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, aw_rdy, w_rdy, b_v, ar_rdy, r_v; // bus
   logic [11:0] aw_a = 0, ar_a = 0;
   logic [31:0] w_d = 0, r_d;
   logic main_en, sub_en, fb_off, run, stop_m, halt_m; // observed outputs
   logic [1:0] sel;
   integer seed = 75, n_mismatch = 0, checks = 0, cyc = 0, fx_cnt = 0, t0, d;
   logic [31:0] q[$]; // expected read data, oldest first
   ccs_clock_ctrl #(.STAB_CYCLES(16)) ccs_clock_ctrl_i (.clk_i, .rst_i, .fx_tick_i, .fxt_tick_i,
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(), .s_axi_bvalid(b_v),
      .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
      .s_axi_rdata(r_d), .s_axi_rresp(), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .wake_i,
      .main_osc_en_o(main_en), .sub_osc_en_o(sub_en), .feedback_resistor_off_o(fb_off), .cpu_run_o(run),
      .cpu_tick_o(), .cpu_clk_sel_o(sel), .periph_tick_o(), .watch_tick_o(), .stop_mode_o(stop_m),
      .halt_mode_o(halt_m));
   initial forever #2.5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////
   // oscillator ticks, cycle count and hang guard
   always @(posedge clk_i) begin
      fx_tick_i <= !fx_tick_i;
      fxt_tick_i <= ($random(seed) & 7) == 0;
      cyc <= cyc + 1;
      if (fx_tick_i) fx_cnt <= fx_cnt + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test;
      end
   end
   // read data monitor takes the oldest note
   always @(posedge clk_i) if (r_v && r_r) chk(r_d, q.pop_front());
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk_bit(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   // write one register, address and data together
   task wr(input logic [11:0] a, input logic [7:0] v);
      logic ad, wd;
      @(posedge clk_i);
      aw_v <= 1; w_v <= 1; aw_a <= a; w_d <= {24'h0, v}; b_r <= 1; ad = 0; wd = 0;
      while (!(ad && wd)) begin
         @(posedge clk_i);
         if (aw_v && aw_rdy) begin ad = 1; aw_v <= 0; end
         if (w_v && w_rdy) begin wd = 1; w_v <= 0; end
      end
      do @(posedge clk_i); while (b_v !== 1);
      b_r <= 0;
   endtask
   // read one register, note the expectation
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_i);
      ar_v <= 1; ar_a <= a; r_r <= 1; q.push_back({24'h0, e});
      do @(posedge clk_i); while (ar_rdy !== 1);
      ar_v <= 0;
      do @(posedge clk_i); while (r_v !== 1);
      r_r <= 0;
   endtask
   task wait_sel(input logic [1:0] v);
      do @(posedge clk_i); while (sel !== v);
   endtask
   // leave standby and wait for the cpu to run
   task wake;
      @(posedge clk_i) wake_i <= 1;
      @(posedge clk_i) wake_i <= 0;
      while (run !== 1) @(posedge clk_i);
   endtask
   task finish_test;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (15) @(posedge clk_i);
      #1 chk_bit(main_en, 0);
      chk({30'h0, sel}, 32'h1);
      @(posedge clk_i) rst_i <= 0;
      t0 = fx_cnt;
      while (run !== 1) @(posedge clk_i);
      chk_bit(fx_cnt - t0 >= 16, 1);
      chk_bit(main_en, 1);
      rd(12'hFFB, 8'h02);
      rd(12'hFF0, 8'h00);
      rd(12'hFF2, 8'h00);
      rd(12'h100, 8'h00);
      wr(12'hFFB, 8'h82);
      rd(12'hFFB, 8'h02);
      chk_bit(main_en, 1);
      for (int i = 0; i < 4; i++) begin
         d = $random(seed) & 3;
         wr(12'hFF0, d[7:0]);
         chk_bit(sub_en, !d[0]);
         chk_bit(fb_off, d[1]);
         rd(12'hFF0, d[7:0]);
      end
      wr(12'hFF0, 8'h00);
      for (int c = 1; c < 3; c++) begin
         wr(12'hF00, c[7:0]);
         rd(12'hF00, 8'(c << 2));
         chk_bit(c == 1 ? stop_m : halt_m, 1);
         wake;
      end
      wr(12'hFFB, 8'h00);
      wait_sel(2'b00);
      t0 = fx_cnt;
      wr(12'hFF2, 8'h10);
      rd(12'hFF2, 8'h10);
      wait_sel(2'b11);
      chk_bit(fx_cnt - t0 >= 300 && fx_cnt - t0 <= 308, 1);
      rd(12'hFF2, 8'h30);
      wr(12'hF00, 8'h01);
      rd(12'hF00, 8'h10);
      chk_bit(stop_m, 0);
      wr(12'hF00, 8'h10);
      rd(12'hF00, 8'h00);
      wr(12'hF00, 8'h02);
      rd(12'hF00, 8'h08);
      wake;
      wr(12'hFFB, 8'h80);
      chk_bit(main_en, 0);
      rd(12'hFFB, 8'h80);
      wr(12'hFFB, 8'h00);
      repeat (64) @(posedge clk_i);
      wr(12'hFF2, 8'h00);
      rd(12'hFF2, 8'h20);
      wait_sel(2'b00);
      rd(12'hFF2, 8'h00);
      finish_test;
   end
endmodule
bind ccs_clock_ctrl ccs_clock_ctrl_chk ccs_clock_ctrl_chk_i (.clk_i, .rst_i, .fx_tick_i, .fxt_tick_i,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .main_osc_en_o, .sub_osc_en_o, .feedback_resistor_off_o, .cpu_run_o,
   .cpu_clk_sel_o, .periph_tick_o, .watch_tick_o, .stop_mode_o);
`default_nettype wire
